// ---- inc/lvrc_defines.svh ----
// register offsets, field positions, reset values and timing counts of the reset controller
`ifndef LVRC_DEFINES_SVH
`define LVRC_DEFINES_SVH

`define ADDR_W              16
`define OFF_RESET_STATUS    16'h1800
`define OFF_FORCE_RESET     16'h1801
`define OFF_OPTIONS_ONE     16'h1802
`define OFF_OPTIONS_TWO     16'h1803
`define OFF_EVENT_STATUS    16'h1804
`define OFF_EVENT_MASK      16'h1805
`define OFF_IDENT_HIGH      16'h1806
`define OFF_IDENT_LOW       16'h1807
`define OFF_POWER_ONE       16'h1809
`define OFF_POWER_TWO       16'h180a

`define SRS_POR_BIT         7
`define SRS_LV_BIT          1
`define SRS_EXT_LSB         3
`define SRS_AFTER_POR       8'h82
`define SRS_AFTER_LV        8'h02

`define FORCE_BIT           0

`define OPT1_STOP_BIT       5
`define OPT1_WMASK          8'he7
`define OPT1_RESET          8'hc2
`define OPT2_WMASK          8'hd3
`define OPT2_RESET          8'h00

`define PM1_FLAG_BIT        7
`define PM1_ACK_BIT         6
`define PM1_WIRQ_BIT        5
`define PM1_DRST_BIT        4
`define PM1_DSTOP_BIT       3
`define PM1_DON_BIT         2
`define PM1_WMASK           8'h3d
`define PM1_RESET           8'h1c

`define PM2_THR_BIT         5
`define PM2_PDF_BIT         3
`define PM2_PDACK_BIT       2
`define PM2_DEEP_BIT        0
`define PM2_WMASK           8'h31
`define PM2_RESET           8'h00

`define EVT_WARN_BIT        0
`define EVT_REFUSE_BIT      1
`define EVT_WAKE_BIT        2
`define EVT_WMASK           8'h07

`define CLK_MHZ             40
`define RST_PULSE_NS        100
`define RST_PULSE_CYC       ((`RST_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- inc/lvrc_pkg.sv ----
// types of the low-voltage reset controller
package lvrc_pkg;

    typedef enum logic [1:0] {
        PH_RUN,
        PH_HOLD_LV,
        PH_PULSE,
        PH_STOP
    } phase_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic lv_low;
        logic lv_warn;
    } detect_in_t;

    typedef struct packed {
        phase_t     phase;
        logic [3:0] cnt;
        logic [7:0] reset_source_status;
        logic [7:0] opt1;
        logic [7:0] opt2;
        logic [7:0] pm1;
        logic       warn_flag;
        logic [7:0] pm2;
        logic       pdf;
        logic [7:0] evt_sts;
        logic [7:0] evt_msk;
        logic [7:0] rdata;
        logic       sys_reset;
        logic       bus_halt;
        logic       cpu_halt;
        logic       deep_stop;
        logic       det_act;
        logic       thr_sel;
        logic       irq;
    } state_t;

endpackage

// ---- hw/low_voltage_reset_control.sv ----
// reset, stop gating and low-voltage supervision for the system control page
//
// Overview of operation
// (RL1) a stop request enters stop only while stop_allow is set
// (RL2) in stop, bus and processor clocks are both halted
// (RL3) control registers sit in the high page starting at 0x1800
// (RL4) detector runs only while detector_on holds 1
// (RL5) entering stop turns the detector off unless detector_on_in_stop is set
// (RL6) with both detector bits set, deep stop is refused; light stop allowed
// (RL7) after power-on reset, hold reset until supply above low threshold
// (RL8) power-on reset sets power-on and low-voltage source flags
// (RL9) with detector_reset_on set, a low-voltage condition issues system reset
// (RL10) detect_threshold_select picks the detector threshold
// (RL11) after low-voltage reset, hold reset until supply back above threshold
// (RL12) low-voltage source flag set after every low-voltage reset too
// (RL13) warning with warning_irq_on set sets warning_flag and requests interrupt
// (RL14) writing 1 to warning_acknowledge clears warning_flag; it reads zero
// (RL15) reset status shows only latest reset sources and ignores writes
// (RL16) writing 1 to background_force_reset resets; it reads zero
`timescale 1ns/1ps
`default_nettype none
`include "lvrc_defines.svh"

module low_voltage_reset_control
    import lvrc_pkg::*;
#(
    parameter logic [11:0] PART_ID = 12'h5a3  // arbitrary value
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // register port
    input  wire bus_req_t   bus,
    output logic [7:0]      rdata,
    // processor side
    input  wire logic       stop_req,
    input  wire logic       wake,
    input  wire logic [3:0] ext_reset_src,
    // analog detector
    input  wire detect_in_t det,
    // control outputs
    output logic            sys_reset,
    output logic            bus_clk_halt,
    output logic            cpu_clk_halt,
    output logic            deep_stop,
    output logic            detector_active,
    output logic            threshold_sel,
    output logic            irq
);

    state_t st_ff;
    state_t nxt_st;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // control registers return to defaults on every system reset
    function automatic state_t ctl_defaults(input state_t s);
        state_t r;
        r = s;
        r.opt1      = `OPT1_RESET;
        r.opt2      = `OPT2_RESET;
        r.pm1       = `PM1_RESET;
        r.pm2       = `PM2_RESET;
        r.warn_flag = 1'b0;
        r.evt_sts   = 8'h00;
        r.evt_msk   = 8'h00;
        ctl_defaults = r;
    endfunction

    always_comb begin
        logic wr_hit;
        logic stop_ok;
        logic go_deep;
        logic in_stop;
        logic lv_rst;
        logic force_rst;
        logic [7:0] rd_val;
        wr_hit    = 1'b0;
        stop_ok   = 1'b0;
        go_deep   = 1'b0;
        in_stop   = 1'b0;
        lv_rst    = 1'b0;
        force_rst = 1'b0;
        rd_val    = 8'h00;
        nxt_st    = st_ff;

        // register writes
        if (bus.wr) begin
            if (hit(bus.addr, `OFF_OPTIONS_ONE)) begin
                nxt_st.opt1 = bus.wdata & `OPT1_WMASK;
            end
            if (hit(bus.addr, `OFF_OPTIONS_TWO)) begin
                nxt_st.opt2 = bus.wdata & `OPT2_WMASK;
            end
            if (hit(bus.addr, `OFF_POWER_ONE)) begin
                nxt_st.pm1 = bus.wdata & `PM1_WMASK;
                if (bus.wdata[`PM1_ACK_BIT]) begin
                    nxt_st.warn_flag = 1'b0;  // [RL14]
                end
            end
            if (hit(bus.addr, `OFF_POWER_TWO)) begin
                nxt_st.pm2 = bus.wdata & `PM2_WMASK;
                if (bus.wdata[`PM2_PDACK_BIT]) begin
                    nxt_st.pdf = 1'b0;
                end
            end
            if (hit(bus.addr, `OFF_EVENT_STATUS)) begin
                nxt_st.evt_sts = st_ff.evt_sts & ~bus.wdata;
            end
            if (hit(bus.addr, `OFF_EVENT_MASK)) begin
                nxt_st.evt_msk = bus.wdata & `EVT_WMASK;
            end
            // reset status has no write path at all [RL15]
            force_rst = hit(bus.addr, `OFF_FORCE_RESET) & bus.wdata[`FORCE_BIT];  // [RL16]
        end

        // register reads: data stands only in the cycle after the strobe
        if (bus.rd) begin
            case (bus.addr)  // [RL3]
                `OFF_RESET_STATUS: rd_val = st_ff.reset_source_status;
                `OFF_OPTIONS_ONE:  rd_val = st_ff.opt1;
                `OFF_OPTIONS_TWO:  rd_val = st_ff.opt2;
                `OFF_EVENT_STATUS: rd_val = st_ff.evt_sts;
                `OFF_EVENT_MASK:   rd_val = st_ff.evt_msk;
                `OFF_IDENT_HIGH:   rd_val = {4'h0, PART_ID[11:8]};
                `OFF_IDENT_LOW:    rd_val = PART_ID[7:0];
                `OFF_POWER_ONE: begin
                    // acknowledge bit always reads zero [RL14]
                    rd_val = st_ff.pm1;
                    rd_val[`PM1_FLAG_BIT] = st_ff.warn_flag;
                end
                `OFF_POWER_TWO: begin
                    rd_val = st_ff.pm2;
                    rd_val[`PM2_PDF_BIT] = st_ff.pdf;
                end
                // force reset register and unmapped addresses read zero [RL16]
                default: rd_val = 8'h00;
            endcase
        end
        nxt_st.rdata = rd_val;

        // detector gating: off in stop unless told to stay on
        in_stop = (st_ff.phase == PH_STOP);
        nxt_st.det_act = st_ff.pm1[`PM1_DON_BIT]
                       & (~in_stop | st_ff.pm1[`PM1_DSTOP_BIT]);  // [RL4] [RL5]
        nxt_st.thr_sel = st_ff.pm2[`PM2_THR_BIT];  // [RL10]

        // warning: flag only when its interrupt is enabled; set beats ack
        if (st_ff.det_act && det.lv_warn) begin
            nxt_st.evt_sts[`EVT_WARN_BIT] = 1'b1;
            if (st_ff.pm1[`PM1_WIRQ_BIT]) begin
                nxt_st.warn_flag = 1'b1;  // [RL13]
            end
        end

        lv_rst = st_ff.det_act & st_ff.pm1[`PM1_DRST_BIT] & det.lv_low;  // [RL9]

        case (st_ff.phase)
            PH_RUN: begin
                if (stop_req) begin
                    stop_ok = st_ff.opt1[`OPT1_STOP_BIT];  // [RL1]
                    // a running detector in stop rules out the deep mode
                    go_deep = st_ff.pm2[`PM2_DEEP_BIT]
                            & ~(st_ff.pm1[`PM1_DON_BIT]
                            & st_ff.pm1[`PM1_DSTOP_BIT]);  // [RL6]
                    if (!stop_ok || (st_ff.pm2[`PM2_DEEP_BIT] && !go_deep)) begin
                        nxt_st.evt_sts[`EVT_REFUSE_BIT] = 1'b1;
                    end
                    if (stop_ok) begin
                        nxt_st.phase     = PH_STOP;
                        nxt_st.bus_halt  = 1'b1;  // [RL2]
                        nxt_st.cpu_halt  = 1'b1;  // [RL2]
                        nxt_st.deep_stop = go_deep;
                        nxt_st.det_act   = st_ff.pm1[`PM1_DON_BIT]
                                         & st_ff.pm1[`PM1_DSTOP_BIT];  // [RL5]
                    end
                end
            end
            PH_STOP: begin
                if (wake) begin
                    nxt_st.phase     = PH_RUN;
                    nxt_st.bus_halt  = 1'b0;
                    nxt_st.cpu_halt  = 1'b0;
                    nxt_st.deep_stop = 1'b0;
                    nxt_st.evt_sts[`EVT_WAKE_BIT] = 1'b1;
                    if (st_ff.deep_stop) begin
                        nxt_st.pdf = 1'b1;
                    end
                end
            end
            PH_HOLD_LV: begin
                // release only once the supply is back above the threshold
                if (!det.lv_low) begin
                    nxt_st.phase     = PH_RUN;
                    nxt_st.sys_reset = 1'b0;  // [RL7] [RL11]
                end
            end
            PH_PULSE: begin
                if (st_ff.cnt == 4'h0) begin
                    nxt_st.phase     = PH_RUN;
                    nxt_st.sys_reset = 1'b0;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            default: begin
                nxt_st.phase = PH_RUN;
            end
        endcase

        // reset sources, low voltage first; each one rewrites the status
        if (st_ff.phase != PH_HOLD_LV) begin
            if (lv_rst) begin
                nxt_st = ctl_defaults(nxt_st);
                nxt_st.phase     = PH_HOLD_LV;
                nxt_st.reset_source_status       = `SRS_AFTER_LV;  // [RL12] [RL15]
                nxt_st.sys_reset = 1'b1;  // [RL9]
                nxt_st.det_act   = 1'b1;
            end else if ((|ext_reset_src) || force_rst) begin
                nxt_st = ctl_defaults(nxt_st);
                nxt_st.phase     = PH_PULSE;
                nxt_st.cnt       = 4'(`RST_PULSE_CYC - 1);
                nxt_st.reset_source_status       = {1'b0, ext_reset_src, 3'b000};  // [RL15] [RL16]
                nxt_st.sys_reset = 1'b1;
            end
            if (lv_rst || (|ext_reset_src) || force_rst) begin
                nxt_st.bus_halt  = 1'b0;
                nxt_st.cpu_halt  = 1'b0;
                nxt_st.deep_stop = 1'b0;
                nxt_st.pdf       = 1'b0;
            end
        end

        // one level interrupt from the warning flag and the masked events
        nxt_st.irq = (nxt_st.warn_flag & nxt_st.pm1[`PM1_WIRQ_BIT])
                   | (|(nxt_st.evt_sts & nxt_st.evt_msk));  // [RL13]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // power-on: start held in reset with both source flags set
            st_ff           <= '0;
            st_ff.phase     <= PH_HOLD_LV;  // [RL7]
            st_ff.reset_source_status       <= `SRS_AFTER_POR;  // [RL8]
            st_ff.opt1      <= `OPT1_RESET;
            st_ff.opt2      <= `OPT2_RESET;
            st_ff.pm1       <= `PM1_RESET;
            st_ff.pm2       <= `PM2_RESET;
            st_ff.sys_reset <= 1'b1;
            st_ff.det_act   <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata           = st_ff.rdata;
    assign sys_reset       = st_ff.sys_reset;
    assign bus_clk_halt    = st_ff.bus_halt;
    assign cpu_clk_halt    = st_ff.cpu_halt;
    assign deep_stop       = st_ff.deep_stop;
    assign detector_active = st_ff.det_act;
    assign threshold_sel   = st_ff.thr_sel;
    assign irq             = st_ff.irq;

endmodule

`default_nettype wire

// ---- sim/lvrc_checker.sv ----
// port assertions for the low-voltage reset controller
`timescale 1ns/1ps
`default_nettype none
`include "lvrc_defines.svh"

module lvrc_checker
    import lvrc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       ce,
    // inputs
    input wire bus_req_t   bus,
    input wire logic       stop_req,
    input wire logic       wake,
    input wire detect_in_t det,
    // outputs
    input wire logic [7:0] rdata,
    input wire logic       sys_reset,
    input wire logic       bus_clk_halt,
    input wire logic       cpu_clk_halt,
    input wire logic       deep_stop,
    input wire logic       detector_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // a force taken during the low-voltage hold starts no pulse; only forces outside reset are checked
    sequence force_wr;
        ce && bus.wr && bus.addr == `OFF_FORCE_RESET && bus.wdata[0] && !sys_reset;
    endsequence
    sequence force_pulse;
        sys_reset [*4] ##1 !sys_reset;
    endsequence

    AST_HALT_PAIR: assert property (bus_clk_halt == cpu_clk_halt)
        else $error("bus and cpu halts differ");
    AST_DEEP_DET_OFF: assert property (deep_stop |-> bus_clk_halt && !detector_active)
        else $error("deep stop with detector running");
    AST_STOP_CAUSE: assert property ($rose(bus_clk_halt) |-> $past(stop_req) || $past(stop_req, 2))
        else $error("halt without stop request");
    AST_WAKE: assert property (ce && wake && bus_clk_halt && !sys_reset |=> !bus_clk_halt)
        else $error("halt kept after wake");
    AST_RDATA_IDLE: assert property (ce && !bus.rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    AST_ACK_ZERO: assert property (ce && bus.rd && bus.addr == `OFF_POWER_ONE |=> !rdata[6])
        else $error("acknowledge bit read as one");
    AST_FORCE_ZERO: assert property (ce && bus.rd && bus.addr == `OFF_FORCE_RESET |=> rdata == 8'h00)
        else $error("force register read nonzero");
    AST_FORCE_PULSE: assert property (force_wr |=> force_pulse)
        else $error("force reset pulse length wrong");
    AST_LV_HOLD: assert property (ce && sys_reset && det.lv_low && detector_active |=> sys_reset)
        else $error("reset released while supply low");
endmodule

bind low_voltage_reset_control lvrc_checker lvrc_checker_inst (.clk, .rstn, .ce, .bus, .stop_req,
    .wake, .det, .rdata, .sys_reset, .bus_clk_halt, .cpu_clk_halt, .deep_stop, .detector_active);
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the low-voltage reset controller
`timescale 1ns/1ps
`default_nettype none
`include "lvrc_defines.svh"

module tb
    import lvrc_pkg::*;
;
    logic       clk, rstn, ce, stop_req, wake, sys_reset, bus_clk_halt, cpu_clk_halt, irq;
    logic       deep_stop, detector_active, threshold_sel;
    logic [3:0] ext_reset_src;
    logic [7:0] rdata;
    bus_req_t   bus;
    detect_in_t det;
    int         failures, compares, cycles;
    // reset values, the unmapped slot 0x1808 included
    logic [15:0] ra [9] = '{16'h1800, 16'h1801, 16'h1802, 16'h1803, 16'h1806, 16'h1807,
                            16'h1808, 16'h1809, 16'h180a};
    logic [7:0]  rv [9] = '{8'h82, 8'h00, 8'hc2, 8'h00, 8'h05, 8'ha3, 8'h00, 8'h1c, 8'h00};

    low_voltage_reset_control #(.PART_ID(12'h5a3)) low_voltage_reset_control_inst (.clk, .rstn,
        .ce, .bus, .rdata, .stop_req, .wake, .ext_reset_src, .det, .sys_reset, .bus_clk_halt,
        .cpu_clk_halt, .deep_stop, .detector_active, .threshold_sel, .irq);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    // e is {halted, deep, detector running}; wake always follows
    task automatic stop_try(input logic [2:0] e);
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        tick(2);
        chk({5'h00, bus_clk_halt, deep_stop, detector_active}, {5'h00, e});
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        tick(2);
        chk({7'h00, cpu_clk_halt}, 8'h00);
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        stop_req = 1'b0;
        wake = 1'b0;
        ext_reset_src = 4'h0;
        bus = '0;
        det = '{lv_low: 1'b1, lv_warn: 1'b0};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        tick(6);
        chk({7'h00, sys_reset}, 8'h01);
        @(posedge clk);
        det.lv_low <= 1'b0;
        tick(3);
        chk({7'h00, sys_reset}, 8'h00);
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(`OFF_RESET_STATUS, 8'hff);
        rd(`OFF_RESET_STATUS, `SRS_AFTER_POR);
        stop_try(3'b001);
        wr(`OFF_OPTIONS_ONE, 8'he2);
        stop_try(3'b101);
        wr(`OFF_POWER_TWO, 8'h01);
        stop_try(3'b101);
        wr(`OFF_POWER_ONE, 8'h14);
        stop_try(3'b110);
        wr(`OFF_POWER_TWO, 8'h20);
        tick(2);
        chk({7'h00, threshold_sel}, 8'h01);
        wr(`OFF_POWER_ONE, 8'h10);
        tick(2);
        chk({7'h00, detector_active}, 8'h00);
        wr(`OFF_POWER_ONE, 8'h3c);
        det.lv_warn <= 1'b1;
        // the detector turns on one edge after the write, so hold the warning for two
        repeat (2) @(posedge clk);
        det.lv_warn <= 1'b0;
        tick(0);
        chk({7'h00, irq}, 8'h01);
        rd(`OFF_POWER_ONE, 8'hbc);
        wr(`OFF_POWER_ONE, 8'h7c);
        rd(`OFF_POWER_ONE, 8'h3c);
        chk({7'h00, irq}, 8'h00);
        wr(`OFF_EVENT_MASK, 8'h01);
        tick(2);
        chk({7'h00, irq}, 8'h01);
        wr(`OFF_EVENT_STATUS, 8'h07);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        // supply dip with the detector reset armed
        @(posedge clk);
        det.lv_low <= 1'b1;
        tick(4);
        chk({7'h00, sys_reset}, 8'h01);
        @(posedge clk);
        det.lv_low <= 1'b0;
        tick(3);
        chk({7'h00, sys_reset}, 8'h00);
        rd(`OFF_RESET_STATUS, `SRS_AFTER_LV);
        wr(`OFF_FORCE_RESET, 8'h01);
        tick(0);
        chk({7'h00, sys_reset}, 8'h01);
        tick(5);
        chk({7'h00, sys_reset}, 8'h00);
        rd(`OFF_RESET_STATUS, 8'h00);
        @(posedge clk);
        ext_reset_src <= 4'h4;
        @(posedge clk);
        ext_reset_src <= 4'h0;
        tick(6);
        rd(`OFF_RESET_STATUS, 8'h20);
        // clock enable low: a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(`OFF_OPTIONS_ONE, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        rd(`OFF_OPTIONS_ONE, `OPT1_RESET);
        finish_test();
    end
endmodule
`default_nettype wire
